/* include/ptc_pkg.sv */
// Constants and types shared by the PTP transmit command decoder
package ptc_pkg;
  localparam int          BEAT_BYTES   = 8;
  localparam int          PIPE_DEPTH   = 6;
  localparam int          TUSER_W      = 128;
  localparam int          TS_W         = 80;
  localparam int          TUSER_CMD_LO = 64;
  localparam int          CMD_CK_BIT   = 8;
  localparam int          CMD_TAG_LO   = 16;
  localparam int          CMD_OFF_LO   = 32;
  localparam int          CMD_CKOFF_LO = 48;
  localparam logic [1:0]  OP_NOP       = 2'h0;
  localparam logic [1:0]  OP_ONE       = 2'h1;
  localparam logic [1:0]  OP_TWO       = 2'h2;
  localparam logic [1:0]  OP_RSV       = 2'h3;
  localparam logic [15:0] CF_TO_CSUM   = 16'h000A;
  localparam logic [15:0] POS_STEP     = 16'h0008;
  localparam logic [3:0]  TOD_LEN      = 4'hA;
  localparam logic [3:0]  CF_LEN       = 4'h8;
  localparam logic [3:0]  CSUM_LEN     = 4'h2;
  localparam logic [2:0]  FLUSH_LAST   = 3'h5;
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;

  typedef enum logic [1:0] {
    PTC_ST_WAIT  = 2'b00,
    PTC_ST_FIRST = 2'b01,
    PTC_ST_BODY  = 2'b10,
    PTC_ST_FLUSH = 2'b11
  } ptc_state_t;
endpackage : ptc_pkg

/* design/ptc_tx_cmd.sv */
// PTP transmit per-frame command decoder and frame modifier
//
// Behaviour
// RULE1 - Decode bits 1:0: none, one-step, two-step
// RULE2 - Code 11 behaves as no operation
// RULE3 - Reserved command bits are ignored
// RULE4 - Two-step: return timestamp, frame unchanged
// RULE5 - Two-step returns tag bits 31:16
// RULE6 - One-step bit 8 requests checksum update
// RULE7 - Bit 8 ignored unless one-step
// RULE8 - Time-of-day stamp written at offset
// RULE9 - Correction field plus timestamp, in place
// RULE10 - Client gives only even offsets
// RULE11 - CRC recomputed over modified frame
// RULE12 - Checksum adjusted incrementally, RFC 1624
// RULE13 - Client checksums with zeroed timestamp
// RULE14 - Correction mode: checksum fixed distance before
// RULE15 - Time-of-day checksum at bits 63:48
// RULE16 - Offsets span full 16-bit frame range
// RULE17 - In-band command beat precedes frame
// RULE18 - Out-of-band command on user 127:64
// RULE19 - Timer sampled at start character
// RULE20 - Two-step return one cycle, in order
`timescale 1ns/10ps
module ptc_tx_cmd #(
  parameter bit CF_FORMAT = 1'b0
) (
  input  wire logic                         clock_in,
  input  wire logic                         sys_rst_in,
  input  wire logic                         inband_cmd_en_in,
  input  wire logic                         start_char_in,
  input  wire logic [ptc_pkg::TS_W-1:0]     timer_in,
  input  wire logic [63:0]                  s_axis_tdata_in,
  input  wire logic [7:0]                   s_axis_tkeep_in,
  input  wire logic                         s_axis_tlast_in,
  input  wire logic [ptc_pkg::TUSER_W-1:0]  s_axis_tuser_in,
  input  wire logic                         s_axis_tvalid_in,
  output logic                              s_axis_tready_out,
  output logic [63:0]                       m_axis_tdata_out,
  output logic [7:0]                        m_axis_tkeep_out,
  output logic                              m_axis_tlast_out,
  output logic [31:0]                       m_axis_fcs_out,
  output logic                              m_axis_tvalid_out,
  input  wire logic                         m_axis_tready_in,
  output logic                              ts_ret_valid_out,
  output logic [ptc_pkg::TS_W-1:0]          ts_ret_out,
  output logic [15:0]                       ts_ret_tag_out
);
  import ptc_pkg::*;

  localparam int LAST  = PIPE_DEPTH - 1;
  localparam int BUF_W = 64 + 8 + 1 + 32;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Big-endian field of len bytes at frame offset off, beat at pos
  function automatic logic [63:0] put_field(input logic [63:0] d, input logic [15:0] pos,
      input logic [15:0] off, input logic [3:0] len, input logic [79:0] val);
    logic [15:0] p;
    logic [15:0] k;
    put_field = d;
    for (int i = 0; i < BEAT_BYTES; i++) begin
      p = pos + 16'(i);
      k = p - off;
      if (p >= off && k < {12'h000, len}) begin
        put_field[i*8 +: 8] = val[(int'(len) - 1 - int'(k))*8 +: 8];
      end
    end
  endfunction : put_field

  function automatic logic [79:0] get_field(input logic [79:0] acc, input logic [63:0] d,
      input logic [15:0] pos, input logic [15:0] off, input logic [3:0] len);
    logic [15:0] p;
    logic [15:0] k;
    get_field = acc;
    for (int i = 0; i < BEAT_BYTES; i++) begin
      p = pos + 16'(i);
      k = p - off;
      if (p >= off && k < {12'h000, len}) begin
        get_field[(int'(len) - 1 - int'(k))*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction : get_field

  function automatic logic [15:0] csum_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    csum_add = s[15:0] + {15'h0000, s[16]};
  endfunction : csum_add

  function automatic logic [15:0] fold80(input logic [79:0] x);
    fold80 = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      fold80 = csum_add(fold80, x[i*16 +: 16]);
    end
  endfunction : fold80

  function automatic logic [31:0] crc_beat(input logic [31:0] c, input logic [63:0] d,
      input logic [7:0] keep);
    crc_beat = c;
    for (int i = 0; i < BEAT_BYTES; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (keep[i]) begin
          crc_beat = (crc_beat[0] ^ d[i*8+b]) ? ((crc_beat >> 1) ^ CRC_POLY)
                                               : (crc_beat >> 1);
        end
      end
    end
  endfunction : crc_beat

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  ptc_state_t        state_r;
  ptc_state_t        state_nxt;
  logic [2:0]        fl_cnt_r;
  logic [15:0]       pos_r;
  logic              one_r;
  logic              two_r;
  logic              ck_r;
  logic [15:0]       tag_r;
  logic [15:0]       off_r;
  logic [15:0]       ckoff_r;
  logic [79:0]       ts_r;
  logic [79:0]       cf_old_r;
  logic [63:0]       sum_r;
  logic [31:0]       crc_r;
  logic [63:0]       p_data_r [PIPE_DEPTH];
  logic [7:0]        p_keep_r [PIPE_DEPTH];
  logic [15:0]       p_pos_r  [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] p_last_r;
  logic [PIPE_DEPTH-1:0] p_vld_r;
  logic [BUF_W-1:0]  ob_r;
  logic [BUF_W-1:0]  sk_r;
  logic              ob_v_r;
  logic              sk_v_r;
  logic              sk_v_nxt;

  wire in_fire     = s_axis_tvalid_in & s_axis_tready_out;
  // RULE17 in-band command beat
  wire is_cmd_beat = in_fire & inband_cmd_en_in & (state_r == PTC_ST_WAIT);
  wire data_fire   = in_fire & ~is_cmd_beat;
  wire first_beat  = data_fire & (state_r != PTC_ST_BODY);
  wire cmd_take    = is_cmd_beat | (data_fire & (state_r == PTC_ST_WAIT));
  wire buf_ready   = ~sk_v_r;
  wire flushing    = state_r == PTC_ST_FLUSH;
  wire adv         = data_fire | (flushing & buf_ready);
  wire push        = adv & p_vld_r[LAST];
  wire pop         = ob_v_r & m_axis_tready_in;
  wire fl_done     = flushing & adv & (fl_cnt_r == FLUSH_LAST);

  // RULE18 out-of-band command source
  wire [63:0] cmd_w = is_cmd_beat ? s_axis_tdata_in
                                  : s_axis_tuser_in[TUSER_CMD_LO +: 64];
  // RULE1 RULE2 RULE3 operation decode
  wire        op_one = cmd_w[1:0] == OP_ONE;
  wire        op_two = cmd_w[1:0] == OP_TWO;
  // RULE7 checksum bit gated
  wire        ck_act = one_r & ck_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PTC_ST_WAIT: begin
        if (is_cmd_beat) begin
          state_nxt = PTC_ST_FIRST;
        end else if (data_fire) begin
          state_nxt = s_axis_tlast_in ? PTC_ST_FLUSH : PTC_ST_BODY;
        end
      end
      PTC_ST_FIRST, PTC_ST_BODY: begin
        if (data_fire) begin
          state_nxt = s_axis_tlast_in ? PTC_ST_FLUSH : PTC_ST_BODY;
        end
      end
      PTC_ST_FLUSH: begin
        if (fl_done) begin
          state_nxt = PTC_ST_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_r  <= PTC_ST_WAIT;
      fl_cnt_r <= 3'h0;
      pos_r    <= 16'h0000;
    end else begin
      state_r  <= state_nxt;
      fl_cnt_r <= (flushing & adv) ? fl_cnt_r + 3'h1 : (flushing ? fl_cnt_r : 3'h0);
      // RULE16 16-bit byte position
      if (data_fire) begin
        pos_r <= first_beat ? POS_STEP : pos_r + POS_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command capture and timestamp
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      one_r   <= 1'b0;
      two_r   <= 1'b0;
      ck_r    <= 1'b0;
      tag_r   <= 16'h0000;
      off_r   <= 16'h0000;
      ckoff_r <= 16'h0000;
      ts_r    <= 80'h0;
    end else begin
      if (cmd_take) begin
        one_r   <= op_one;
        two_r   <= op_two;
        ck_r    <= cmd_w[CMD_CK_BIT];
        tag_r   <= cmd_w[CMD_TAG_LO +: 16];
        off_r   <= cmd_w[CMD_OFF_LO +: 16];
        ckoff_r <= cmd_w[CMD_CKOFF_LO +: 16];
      end
      // RULE19 timer sample
      if (start_char_in) begin
        ts_r <= timer_in;
      end
    end
  end

  // Six stages give the correction sum time to settle before the
  // checksum, up to three beats earlier, leaves the last stage.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      p_vld_r  <= '0;
      p_last_r <= '0;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        p_data_r[i] <= 64'h0;
        p_keep_r[i] <= 8'h00;
        p_pos_r[i]  <= 16'h0000;
      end
    end else if (adv) begin
      p_vld_r  <= {p_vld_r[LAST-1:0], data_fire};
      p_last_r <= {p_last_r[LAST-1:0], data_fire & s_axis_tlast_in};
      p_data_r[0] <= s_axis_tdata_in;
      p_keep_r[0] <= s_axis_tkeep_in;
      p_pos_r[0]  <= first_beat ? 16'h0000 : pos_r;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        p_data_r[i] <= p_data_r[i-1];
        p_keep_r[i] <= p_keep_r[i-1];
        p_pos_r[i]  <= p_pos_r[i-1];
      end
    end
  end

  // RULE9 gather old correction field
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || cmd_take) begin
      cf_old_r <= 80'h0;
      sum_r    <= 64'h0;
    end else begin
      if (CF_FORMAT && one_r && p_vld_r[0]) begin
        cf_old_r <= get_field(cf_old_r, p_data_r[0], p_pos_r[0], off_r, CF_LEN);
      end
      sum_r <= cf_old_r[63:0] + ts_r[63:0];
    end
  end

  // ----------------------------------------------------------------
  // Frame modification at the last stage
  // ----------------------------------------------------------------
  wire [63:0] d_last  = p_data_r[LAST];
  wire [15:0] pos_l   = p_pos_r[LAST];
  // RULE14 RULE15 checksum location
  wire [15:0] ck_off  = CF_FORMAT ? off_r - CF_TO_CSUM : ckoff_r;
  wire [79:0] old_ck  = get_field(80'h0, d_last, pos_l, ck_off, CSUM_LEN);
  // RULE12 incremental checksum delta
  wire [15:0] delta   = CF_FORMAT ? csum_add(fold80({16'h0000, sum_r}),
                                             fold80({16'h0000, ~cf_old_r[63:0]}))
                                  : fold80(ts_r);
  wire [15:0] ck_sum  = ~csum_add(~old_ck[15:0], delta);
  wire [15:0] new_ck  = (ck_sum == 16'h0000) ? 16'hFFFF : ck_sum;
  wire [79:0] fld_val = CF_FORMAT ? {16'h0000, sum_r} : ts_r;
  wire [3:0]  fld_len = CF_FORMAT ? CF_LEN : TOD_LEN;
  // RULE8 RULE9 field write
  wire [63:0] d_ins   = one_r ? put_field(d_last, pos_l, off_r, fld_len, fld_val) : d_last;
  // RULE6 checksum rewrite
  wire [63:0] d_mod   = ck_act ? put_field(d_ins, pos_l, ck_off, CSUM_LEN, {64'h0, new_ck})
                               : d_ins;
  // RULE11 CRC over sent bytes
  wire [31:0] crc_w   = crc_beat(crc_r, d_mod, p_keep_r[LAST]);
  wire [BUF_W-1:0] buf_in = {d_mod, p_keep_r[LAST], p_last_r[LAST],
                             p_last_r[LAST] ? ~crc_w : 32'h0};

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      crc_r            <= CRC_INIT;
      ts_ret_valid_out <= 1'b0;
      ts_ret_out       <= 80'h0;
      ts_ret_tag_out   <= 16'h0000;
    end else begin
      if (push) begin
        crc_r <= p_last_r[LAST] ? CRC_INIT : crc_w;
      end
      // RULE4 RULE5 RULE20 two-step return
      ts_ret_valid_out <= push & p_last_r[LAST] & two_r;
      if (push && p_last_r[LAST] && two_r) begin
        ts_ret_out     <= ts_r;
        ts_ret_tag_out <= tag_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------
  // Skid entry absorbs one beat when the receiver stalls
  assign sk_v_nxt = sk_v_r ? ~pop : (push & ob_v_r & ~pop);
  assign m_axis_tdata_out = ob_r[BUF_W-1 -: 64];
  assign m_axis_tkeep_out = ob_r[33 +: 8];
  assign m_axis_tlast_out = ob_r[32];
  assign m_axis_fcs_out   = ob_r[31:0];
  assign m_axis_tvalid_out = ob_v_r;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ob_r              <= '0;
      sk_r              <= '0;
      ob_v_r            <= 1'b0;
      sk_v_r            <= 1'b0;
      s_axis_tready_out <= 1'b0;
    end else begin
      sk_v_r            <= sk_v_nxt;
      s_axis_tready_out <= ~sk_v_nxt & (state_nxt != PTC_ST_FLUSH);
      if (sk_v_r) begin
        if (pop) begin
          ob_r <= sk_r;
        end
      end else if (push) begin
        if (!ob_v_r || pop) begin
          ob_r   <= buf_in;
          ob_v_r <= 1'b1;
        end else begin
          sk_r <= buf_in;
        end
      end else if (pop) begin
        ob_v_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_op_one_step: assert property (cmd_take && cmd_w[1:0] == OP_ONE |=> one_r && !two_r) // RULE1
    else $error("one-step code not decoded");
  a_op_reserved_nop: assert property (cmd_take && cmd_w[1:0] == OP_RSV |=> !one_r && !two_r) // RULE2
    else $error("reserved code not treated as no operation");
  a_two_step_clean: assert property (p_vld_r[LAST] && two_r |-> d_mod == d_last) // RULE4
    else $error("two-step frame was modified");
  a_tag_returned: assert property (push && p_last_r[LAST] && two_r
                                   |=> ts_ret_valid_out && ts_ret_tag_out == $past(tag_r)) // RULE5
    else $error("two-step tag not returned");
  a_ck_select: assert property (cmd_take && op_one && cmd_w[CMD_CK_BIT] |=> ck_act) // RULE6
    else $error("checksum update not selected");
  a_ck_ignored: assert property (cmd_take && !op_one |=> !ck_act) // RULE7
    else $error("checksum bit honoured outside one-step");
  a_inband_consumed: assert property (is_cmd_beat |=> state_r == PTC_ST_FIRST && !p_vld_r[0]) // RULE17
    else $error("in-band command beat entered the frame path");
  a_ret_one_cycle: assert property (ts_ret_valid_out |=> !ts_ret_valid_out [*2]) // RULE20
    else $error("timestamp return longer than one cycle");
  a_out_hold: assert property (m_axis_tvalid_out && !m_axis_tready_in
                               |=> m_axis_tvalid_out && $stable(m_axis_tdata_out))
    else $error("output beat changed while stalled");

  c_two_step: cover property (ts_ret_valid_out);
  c_one_step_ck: cover property (push && ck_act);
  c_inband_cmd: cover property (is_cmd_beat ##1 data_fire);
  c_stall_full: cover property (sk_v_r && !m_axis_tready_in);

endmodule : ptc_tx_cmd

/* dv/ptc_client_model.sv */
// Client transmit stream source feeding the PTP command decoder
`timescale 1ns/10ps
module ptc_client_model (
  input  wire logic          clock_in,
  input  wire logic          s_axis_tready_in,
  output logic [63:0]        s_axis_tdata_out,
  output logic [7:0]         s_axis_tkeep_out,
  output logic               s_axis_tlast_out,
  output logic [127:0]       s_axis_tuser_out,
  output logic               s_axis_tvalid_out
);
  import ptc_pkg::*;

  logic [7:0] frame_b [0:511];

  initial begin
    s_axis_tdata_out  = 64'h0;
    s_axis_tkeep_out  = 8'h00;
    s_axis_tlast_out  = 1'b0;
    s_axis_tuser_out  = 128'h0;
    s_axis_tvalid_out = 1'b0;
  end

  // -----------------------------------------------
  // Beat hand-over
  // -----------------------------------------------
  // Entered at a falling edge; held until an edge sees ready high
  task automatic put_beat(input logic [63:0] d, input logic [7:0] k, input logic l,
                          input logic [127:0] u);
    logic ok;
    s_axis_tdata_out  = d;
    s_axis_tkeep_out  = k;
    s_axis_tlast_out  = l;
    s_axis_tuser_out  = u;
    s_axis_tvalid_out = 1'b1;
    ok = 1'b0;
    while (!ok) begin
      ok = (s_axis_tready_in === 1'b1);
      @(posedge clock_in);
      @(negedge clock_in);
    end
  endtask : put_beat

  task automatic send_frame(input int len, input logic [63:0] cmd, input logic inband);
    logic [63:0] d;
    logic [7:0]  k;
    int          b;
    int          i;
    if (inband) put_beat(cmd, 8'hFF, 1'b0, ~s_axis_tuser_out);
    for (b = 0; b * 8 < len; b++) begin
      d = 64'h0;
      k = 8'h00;
      for (i = 0; i < 8; i++) begin
        if (b * 8 + i < len) begin
          d[8*i +: 8] = frame_b[b*8+i];
          k[i] = 1'b1;
        end
      end
      put_beat(d, k, (b + 1) * 8 >= len, (b == 0 && !inband) ? {cmd, 64'h0} : {~cmd, ~d});
    end
    // Released lines show no stale beat
    s_axis_tvalid_out = 1'b0;
    s_axis_tlast_out  = 1'b0;
    s_axis_tdata_out  = ~s_axis_tdata_out;
    s_axis_tuser_out  = ~s_axis_tuser_out;
  endtask : send_frame
endmodule : ptc_client_model

/* dv/ptp_tx_frame_command_decoder_test.sv */
// Self-checking bench for the PTP transmit command decoder
`timescale 1ns/10ps
module ptp_tx_frame_command_decoder_test;
  import ptc_pkg::*;

  logic          clock_in, sys_rst_in, inband_cmd_en_in, start_char_in;
  logic [79:0]   timer_in, stamp, ts_seen;
  logic [63:0]   s_tdata, m_axis_tdata_out;
  logic [7:0]    s_tkeep, m_axis_tkeep_out;
  logic [127:0]  s_tuser;
  logic          s_tlast, s_tvalid, s_axis_tready_out;
  logic          m_axis_tlast_out, m_axis_tvalid_out, m_axis_tready_in;
  logic [31:0]   m_axis_fcs_out, fcs_seen;
  logic          ts_ret_valid_out;
  logic [79:0]   ts_ret_out;
  logic [15:0]   ts_ret_tag_out, tag_seen, csum;
  logic [7:0]    exp_b [0:511];
  logic [7:0]    out_q [$];
  logic [1:0]    stall_mode;
  logic [1:0]    ops [3] = '{OP_NOP, OP_RSV, OP_TWO};
  logic [63:0]   cf_tdata;
  logic [7:0]    cf_tkeep;
  logic [31:0]   cf_fcs, cf_fcs_seen;
  logic          cf_tlast, cf_tvalid;
  logic [7:0]    cf_q [$];
  int            bad_count, tests_run, frames_out, ts_count, phase, refusals;

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  ptc_tx_cmd #(.CF_FORMAT(1'b0)) u_ptc_tx_cmd (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .inband_cmd_en_in(inband_cmd_en_in),
    .start_char_in(start_char_in), .timer_in(timer_in), .s_axis_tdata_in(s_tdata),
    .s_axis_tkeep_in(s_tkeep), .s_axis_tlast_in(s_tlast), .s_axis_tuser_in(s_tuser),
    .s_axis_tvalid_in(s_tvalid), .s_axis_tready_out(s_axis_tready_out),
    .m_axis_tdata_out(m_axis_tdata_out), .m_axis_tkeep_out(m_axis_tkeep_out),
    .m_axis_tlast_out(m_axis_tlast_out), .m_axis_fcs_out(m_axis_fcs_out),
    .m_axis_tvalid_out(m_axis_tvalid_out), .m_axis_tready_in(m_axis_tready_in),
    .ts_ret_valid_out(ts_ret_valid_out), .ts_ret_out(ts_ret_out),
    .ts_ret_tag_out(ts_ret_tag_out));

  // Correction-field format twin, fed the same stream in lockstep
  ptc_tx_cmd #(.CF_FORMAT(1'b1)) u_ptc_tx_cmd_cf (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .inband_cmd_en_in(inband_cmd_en_in),
    .start_char_in(start_char_in), .timer_in(timer_in), .s_axis_tdata_in(s_tdata),
    .s_axis_tkeep_in(s_tkeep), .s_axis_tlast_in(s_tlast), .s_axis_tuser_in(s_tuser),
    .s_axis_tvalid_in(s_tvalid), .s_axis_tready_out(),
    .m_axis_tdata_out(cf_tdata), .m_axis_tkeep_out(cf_tkeep),
    .m_axis_tlast_out(cf_tlast), .m_axis_fcs_out(cf_fcs),
    .m_axis_tvalid_out(cf_tvalid), .m_axis_tready_in(m_axis_tready_in),
    .ts_ret_valid_out(), .ts_ret_out(), .ts_ret_tag_out());

  ptc_client_model u_ptc_client_model (
    .clock_in(clock_in), .s_axis_tready_in(s_axis_tready_out), .s_axis_tdata_out(s_tdata),
    .s_axis_tkeep_out(s_tkeep), .s_axis_tlast_out(s_tlast), .s_axis_tuser_out(s_tuser),
    .s_axis_tvalid_out(s_tvalid));

  // -----------------------------------------------
  // Sink and return monitor
  // -----------------------------------------------
  // Sampled at falling edges, where registered outputs are settled
  always @(negedge clock_in) begin
    // Ready set first, so the beat logged is the one the next edge takes
    phase++;
    m_axis_tready_in = (stall_mode == 2'h0) || (stall_mode == 2'h1 && phase % 4 != 3);
    if (cf_tvalid === 1'b1 && m_axis_tready_in === 1'b1) begin
      for (int i = 0; i < 8; i++) if (cf_tkeep[i]) cf_q.push_back(cf_tdata[8*i +: 8]);
      if (cf_tlast === 1'b1) cf_fcs_seen = cf_fcs;
    end
    if (m_axis_tvalid_out === 1'b1 && m_axis_tready_in === 1'b1) begin
      for (int i = 0; i < 8; i++) if (m_axis_tkeep_out[i]) out_q.push_back(m_axis_tdata_out[8*i +: 8]);
      if (m_axis_tlast_out === 1'b1) begin
        fcs_seen = m_axis_fcs_out;
        frames_out++;
      end
    end
    if (ts_ret_valid_out === 1'b1) begin
      ts_count++;
      ts_seen  = ts_ret_out;
      tag_seen = ts_ret_tag_out;
    end
    if (stall_mode == 2'h2 && s_tvalid === 1'b1 && s_axis_tready_out === 1'b0) refusals++;
  end

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  function automatic logic [63:0] cmd_of(input logic [1:0] op, input logic ck,
                                         input logic [15:0] tag, input logic [15:0] off,
                                         input logic [15:0] ckoff);
    return {ckoff, off, tag, 7'h55, ck, 6'h2A, op};
  endfunction : cmd_of

  function automatic logic [31:0] fcs_of(input int len);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < len; i++) begin
      c = c ^ {24'h000000, exp_b[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction : fcs_of

  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc_add

  task automatic prep(input int len);
    stamp = stamp + 80'h0001_0000_0203_0000_0405;
    for (int i = 0; i < len; i++) begin
      u_ptc_client_model.frame_b[i] = 8'(i * 7 + 8'h3B);
      exp_b[i] = 8'(i * 7 + 8'h3B);
    end
  endtask : prep

  task automatic put_stamp(input int off);
    for (int k = 0; k < 10; k++) begin
      u_ptc_client_model.frame_b[off+k] = 8'h00;
      exp_b[off+k] = stamp[79-8*k -: 8];
    end
  endtask : put_stamp

  task automatic run_frame(input int len, input logic [63:0] cmd, input logic inband,
                           input logic exp_ret);
    int n0;
    int t0;
    int w;
    n0 = frames_out;
    t0 = ts_count;
    out_q.delete();
    cf_q.delete();
    inband_cmd_en_in = inband;
    timer_in = stamp;
    start_char_in = 1'b1;
    @(negedge clock_in);
    start_char_in = 1'b0;
    timer_in = ~stamp;
    u_ptc_client_model.send_frame(len, cmd, inband);
    w = 0;
    while (frames_out == n0 && w < 2000) begin
      @(negedge clock_in);
      w++;
    end
    repeat (3) @(negedge clock_in);
    check("frame length", 80'(out_q.size()), 80'(len));
    for (int i = 0; i < len && i < out_q.size(); i++) check("frame byte", 80'(out_q[i]), 80'(exp_b[i]));
    check("fcs", 80'(fcs_seen), 80'(fcs_of(len)));
    check("return count", 80'(ts_count - t0), 80'(exp_ret));
    if (exp_ret) begin
      check("return stamp", ts_seen, stamp);
      check("return tag", 80'(tag_seen), 80'(cmd[31:16]));
    end
  endtask : run_frame

  initial begin
    #300000;
    bad_count++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    sys_rst_in = 1'b1;
    inband_cmd_en_in = 1'b0;
    start_char_in = 1'b0;
    timer_in = 80'h0;
    m_axis_tready_in = 1'b0;
    stall_mode = 2'h0;
    stamp = 80'h0000_1234_5678_0ABC_DEF0;
    repeat (20) @(negedge clock_in);
    check("reset tready", 80'(s_axis_tready_out), 80'h0);
    check("reset valid", 80'({m_axis_tvalid_out, ts_ret_valid_out}), 80'h0);
    sys_rst_in = 1'b0;
    @(negedge clock_in);
    foreach (ops[n]) begin
      prep(45 + n * 8);
      run_frame(45 + n * 8, cmd_of(ops[n], 1'b1, 16'hBEE0 + 16'(n), 16'h000A, 16'h0014),
                n[0], ops[n] == OP_TWO);
    end
    // stamp beyond byte 255, no checksum update
    prep(280);
    put_stamp(266);
    run_frame(280, cmd_of(OP_ONE, 1'b0, 16'h7777, 16'h010A, 16'h0014), 1'b0, 1'b0);
    // zeroed correction field plus stamp, in place
    for (int k = 0; k < 10; k++) exp_b[266+k] = (k < 8) ? stamp[63-8*k -: 8] : 8'h00;
    check("cf length", 80'(cf_q.size()), 80'h118);
    for (int i = 0; i < 280 && i < cf_q.size(); i++) check("cf byte", 80'(cf_q[i]), 80'(exp_b[i]));
    check("cf fcs", 80'(cf_fcs_seen), 80'(fcs_of(280)));
    // even offsets; checksum ahead of stamp, sink stalling
    prep(64);
    u_ptc_client_model.frame_b[34] = 8'h3A;
    u_ptc_client_model.frame_b[35] = 8'h5C;
    put_stamp(46);
    csum = ~16'h3A5C;
    for (int k = 0; k < 5; k++) csum = oc_add(csum, stamp[79-16*k -: 16]);
    csum = ~csum;
    if (csum == 16'h0000) csum = 16'hFFFF;
    exp_b[34] = csum[15:8];
    exp_b[35] = csum[7:0];
    stall_mode = 2'h1;
    run_frame(64, cmd_of(OP_ONE, 1'b1, 16'h1111, 16'h002E, 16'h0022), 1'b1, 1'b0);
    // Long sink stall: buffer fills and input is refused, nothing lost
    prep(280);
    refusals = 0;
    fork
      begin
        stall_mode = 2'h2;
        repeat (60) @(negedge clock_in);
        stall_mode = 2'h0;
      end
      run_frame(280, cmd_of(OP_TWO, 1'b1, 16'hC0DE, 16'h0010, 16'h0020), 1'b0, 1'b1);
    join
    check("refused under stall", 80'(refusals > 20), 80'h1);
    complete_run();
  end
endmodule : ptp_tx_frame_command_decoder_test
